/* File: hdl/boost_limit_status_regs.sv */
// Roof threshold, current-limit settings and status flags of the converter bank.
// Assumes a serial-bus front end giving one-cycle read/write strobes on i_mclk;
// analog status arrives asynchronously and is synchronised here.
// How it works
// - The roof threshold is a five-bit code, 2.850V at zero rising 50mV a step to 4.400V.
// - Bits 7:6 of the current-limit register ignore writes and read as zero.
// - Bit 5 of the current-limit register disables the current limit when set.
// - Bit 4 picks a fixed 1250mA soft-start limit when set, else the valley code.
// - The four-bit valley code picks the boost valley current, 1500mA to 5000mA.
// - Status bit 7 latches on a thermal trip and clears after a status read.
// - Status bit 6 shows the live hot-die comparison without latching.
// - Status bit 5 shows PFM as one and PWM as zero.
// - Status bit 4 shows dc/dc mode as one and pass-through as zero.
// - Status bit 3 latches on a bypass current-limit trip in pass-through until a status read.
// - Status bit 2 latches once the average input limit stays active 1.5ms in boost.
// - Status bit 1 latches on any fault until a status read.
// - Status bit 0 shows output in range, and reads one when forced into pass-through.
`timescale 1ns/10ps
`include "boost_limit_defines.svh"

module boost_limit_status_regs #(
  parameter int BOOST_LIMIT_CYCLES = `BOOST_LIMIT_TIME_US * `MCLK_MHZ
) (
  // Clock and reset
  input  wire logic                             i_mclk,
  input  wire logic                             i_srst,
  // Register access strobes
  input  wire logic                             i_wr_stb,
  input  wire logic                             i_rd_stb,
  input  wire logic [7:0]                       i_addr,
  input  wire logic [7:0]                       i_wdata,
  output logic      [7:0]                       o_rdata,
  // Analog status, asynchronous
  input  wire boost_limit_pkg::analog_status_t  i_status,
  // Settings to the regulation loop
  output logic      [4:0]                       o_roof_threshold_code,
  output boost_limit_pkg::current_limit_t       o_current_limit
);
  import boost_limit_pkg::*;

  // ----------------------------------------
  // Status synchroniser
  // ----------------------------------------
  analog_status_t sync1_reg, sync2_reg;

  // Two stages; only sync2 is read by logic
  // Bits cross on their own, so two levels that move together may land an edge apart
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= i_status;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Settings registers
  // ----------------------------------------
  logic [4:0]     roof_reg, roof_next;
  current_limit_t valley_limit_code_reg, valley_limit_code_next;

  // Writes keep only implemented bits; reserved bits are dropped
  always_comb begin
    roof_next = roof_reg;
    valley_limit_code_next = valley_limit_code_reg;
    if (i_wr_stb && i_addr == `ROOF_THRESHOLD_ADDR) begin
      roof_next = i_wdata[4:0];
    end
    if (i_wr_stb && i_addr == `CURRENT_LIMIT_ADDR) begin
      valley_limit_code_next = i_wdata[5:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      roof_reg <= `ROOF_THRESHOLD_RESET;
      valley_limit_code_reg <= `CURRENT_LIMIT_RESET;
    end else begin
      roof_reg <= roof_next;
      valley_limit_code_reg <= valley_limit_code_next;
    end
  end

  // Settings leave straight from flip-flops, so the loop never sees a glitch
  assign o_roof_threshold_code = roof_reg;
  assign o_current_limit       = valley_limit_code_reg;

  // ----------------------------------------
  // Boost average-limit timer
  // ----------------------------------------
  localparam int CW = $clog2(BOOST_LIMIT_CYCLES + 1);
  logic [CW-1:0] avg_cnt_reg, avg_cnt_next;
  logic          avg_hit;

  // Counts while the average limit is active in dc/dc mode; restarts on any gap
  // Limitation: a single quiet cycle restarts the whole window, by design
  always_comb begin
    avg_hit      = 1'b0;
    avg_cnt_next = '0;
    if (sync2_reg.avg_limit_active && sync2_reg.dcdc_mode) begin
      if (avg_cnt_reg == CW'(BOOST_LIMIT_CYCLES - 1)) begin
        avg_hit      = 1'b1;
        avg_cnt_next = avg_cnt_reg;
      end else begin
        avg_cnt_next = avg_cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      avg_cnt_reg <= '0;
    end else begin
      avg_cnt_reg <= avg_cnt_next;
    end
  end

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  logic [3:0] sticky_reg, sticky_next; // thermal, bypass, boost, fault
  logic [3:0] sticky_set;
  logic       stat_rd;

  assign stat_rd = i_rd_stb && i_addr == `CONDITION_FLAGS_ADDR;

  // Set beats the read-clear so an event during a read is kept
  // A source that stays high therefore re-arms its flag on every read
  always_comb begin
    sticky_set = {sync2_reg.thermal_trip,
                  sync2_reg.bypass_limit && !sync2_reg.dcdc_mode,
                  avg_hit,
                  sync2_reg.fault};
    sticky_next = (stat_rd ? 4'h0 : sticky_reg) | sticky_set;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sticky_reg <= '0;
    end else begin
      sticky_reg <= sticky_next;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  condition_flags_t flags;
  logic [7:0]       rdata_reg, rdata_next;

  // Live bits come straight from the synchronised inputs
  always_comb begin
    flags.thermal_trip_flag        = sticky_reg[3];
    flags.hot_die_indicator        = sync2_reg.hot_die;
    flags.switching_mode_indicator = sync2_reg.pfm_mode;
    flags.operating_path_indicator = sync2_reg.dcdc_mode;
    flags.bypass_overcurrent_flag  = sticky_reg[2];
    flags.boost_overcurrent_flag   = sticky_reg[1];
    flags.fault_flag               = sticky_reg[0];
    flags.output_in_range = sync2_reg.power_good | sync2_reg.forced_bypass;
  end

  // Read returns pre-clear values; reserved bits and unmapped reads are zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd_stb) begin
      unique case (i_addr)
        `ROOF_THRESHOLD_ADDR:   rdata_next = {3'h0, roof_reg};
        `CURRENT_LIMIT_ADDR:    rdata_next = {2'h0, valley_limit_code_reg};
        `CONDITION_FLAGS_ADDR:  rdata_next = flags;
        default:                rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  thermal_sticky_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    sync2_reg.thermal_trip |=> sticky_reg[3])
    else $error("thermal flag not latched");
  sticky_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (stat_rd && sticky_set == 4'h0) |=> sticky_reg == 4'h0)
    else $error("sticky flags not cleared by read");
  sticky_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (sticky_reg[0] && !stat_rd) |=> sticky_reg[0])
    else $error("fault flag dropped without read");
  read_capture_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    stat_rd |=> o_rdata[7] == $past(sticky_reg[3]) && o_rdata[1] == $past(sticky_reg[0]))
    else $error("status read not pre-clear");
  valley_limit_code_reserved_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_rd_stb && i_addr == `CURRENT_LIMIT_ADDR) |=> o_rdata[7:6] == 2'h0)
    else $error("reserved bits not zero");
  valley_limit_code_write_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr_stb && i_addr == `CURRENT_LIMIT_ADDR)
      |=> o_current_limit.limit_disable == $past(i_wdata[5]))
    else $error("limit disable not written");
  roof_write_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr_stb && i_addr == `ROOF_THRESHOLD_ADDR)
      |=> o_roof_threshold_code == $past(i_wdata[4:0]))
    else $error("roof code not written");
  boost_timer_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    avg_hit |-> avg_cnt_reg == CW'(BOOST_LIMIT_CYCLES - 1))
    else $error("boost flag early");
  in_range_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (stat_rd && sync2_reg.forced_bypass) |=> o_rdata[0])
    else $error("in-range not forced in bypass");

  // ----------------------------------------
  // Reset, hold and read-back checks
  // ----------------------------------------
  // Reset loads the power-up roof code
  roof_reset_a: assert property (@(posedge i_mclk)
    i_srst |=> o_roof_threshold_code == `ROOF_THRESHOLD_RESET)
    else $error("roof reset value wrong");
  // Reset loads the power-up current-limit settings
  valley_limit_code_reset_a: assert property (@(posedge i_mclk)
    i_srst |=> o_current_limit == `CURRENT_LIMIT_RESET)
    else $error("current limit reset value wrong");
  // Reset clears every flag and the read data
  flags_reset_a: assert property (@(posedge i_mclk)
    i_srst |=> sticky_reg == 4'h0 && o_rdata == 8'h00)
    else $error("flags not cleared by reset");
  // Roof code only moves on its own write
  roof_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !(i_wr_stb && i_addr == `ROOF_THRESHOLD_ADDR) |=> $stable(o_roof_threshold_code))
    else $error("roof code moved without write");
  // Current-limit settings only move on their own write
  valley_limit_code_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !(i_wr_stb && i_addr == `CURRENT_LIMIT_ADDR) |=> $stable(o_current_limit))
    else $error("current limit moved without write");
  // Soft-start choice follows the written bit
  soft_start_write_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr_stb && i_addr == `CURRENT_LIMIT_ADDR)
      |=> o_current_limit.soft_start_fixed == $past(i_wdata[4]))
    else $error("soft-start choice not written");
  // Valley code follows the written nibble
  valley_write_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr_stb && i_addr == `CURRENT_LIMIT_ADDR)
      |=> o_current_limit.valley_limit_code == $past(i_wdata[3:0]))
    else $error("valley code not written");
  // Upper roof bits always read back as zero
  roof_reserved_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_rd_stb && i_addr == `ROOF_THRESHOLD_ADDR) |=> o_rdata[7:5] == 3'h0)
    else $error("roof reserved bits not zero");
  // Hot-die bit is the live comparison at the read edge
  hot_die_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    stat_rd |=> o_rdata[6] == $past(sync2_reg.hot_die))
    else $error("hot-die bit not live");
  // Switching-mode bit is live
  pfm_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    stat_rd |=> o_rdata[5] == $past(sync2_reg.pfm_mode))
    else $error("switching mode bit not live");
  // Operating-path bit is live
  path_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    stat_rd |=> o_rdata[4] == $past(sync2_reg.dcdc_mode))
    else $error("operating path bit not live");
  // Bypass trip in pass-through latches
  bypass_sticky_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (sync2_reg.bypass_limit && !sync2_reg.dcdc_mode) |=> sticky_reg[2])
    else $error("bypass flag not latched");
  // Full boost window latches
  boost_sticky_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    avg_hit |=> sticky_reg[1])
    else $error("boost flag not latched");
  // Any fault latches
  fault_sticky_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    sync2_reg.fault |=> sticky_reg[0])
    else $error("fault flag not latched");
  // Current-limit flags read back as they stood before the clear
  flag_capture_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    stat_rd |=> o_rdata[3] == $past(sticky_reg[2]) && o_rdata[2] == $past(sticky_reg[1]))
    else $error("limit flags not pre-clear");
  // In-range bit is live, forced high by forced pass-through
  in_range_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    stat_rd |=> o_rdata[0] == $past(sync2_reg.power_good | sync2_reg.forced_bypass))
    else $error("in-range bit wrong");
  // Any gap in the average limit restarts the window
  timer_restart_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !(sync2_reg.avg_limit_active && sync2_reg.dcdc_mode) |=> avg_cnt_reg == CW'(0))
    else $error("boost timer not restarted");
  // Thermal flag holds until a status read
  thermal_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (sticky_reg[3] && !stat_rd) |=> sticky_reg[3])
    else $error("thermal flag dropped without read");
  // Read data stands until the next read
  rdata_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !i_rd_stb |=> $stable(o_rdata))
    else $error("read data moved without read");
  // A write to the status register changes no flag
  status_nowrite_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr_stb && i_addr == `CONDITION_FLAGS_ADDR && !stat_rd && sticky_set == 4'h0)
      |=> sticky_reg == $past(sticky_reg))
    else $error("status write changed flags");

endmodule : boost_limit_status_regs

/* File: inc/boost_limit_defines.svh */
// Register map and field constants for the boost limit and status bank.
// Assumes inclusion by the package and the bank module by bare name.
`ifndef BOOST_LIMIT_DEFINES_SVH
`define BOOST_LIMIT_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ROOF_THRESHOLD_ADDR    8'h03
`define CURRENT_LIMIT_ADDR     8'h04
`define CONDITION_FLAGS_ADDR   8'h05
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ROOF_THRESHOLD_RESET   5'h0a
`define CURRENT_LIMIT_RESET    6'h1b
// ----------------------------------------
// Timing
// ----------------------------------------
`define BOOST_LIMIT_TIME_US    1500
`define MCLK_MHZ               10
`endif

/* File: inc/boost_limit_pkg.sv */
// Types shared by the boost limit and status bank.
// Assumes the defines header sits on the include path.
package boost_limit_pkg;
  `include "boost_limit_defines.svh"

  // Current-limit setting fields, bit 5 down to bit 0
  typedef struct packed {
    logic       limit_disable;
    logic       soft_start_fixed;
    logic [3:0] valley_limit_code;
  } current_limit_t;

  // Status byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic thermal_trip_flag;
    logic hot_die_indicator;
    logic switching_mode_indicator;
    logic operating_path_indicator;
    logic bypass_overcurrent_flag;
    logic boost_overcurrent_flag;
    logic fault_flag;
    logic output_in_range;
  } condition_flags_t;

  // Raw inputs from the analog side
  typedef struct packed {
    logic thermal_trip;
    logic hot_die;
    logic pfm_mode;
    logic dcdc_mode;
    logic bypass_limit;
    logic avg_limit_active;
    logic fault;
    logic power_good;
    logic forced_bypass;
  } analog_status_t;
endpackage : boost_limit_pkg

/* File: tb/host_strobe_model.sv */
// Host side of the bank: one-cycle write and read strobes on the control clock.
// Assumes the bank answers a read one edge after the strobe edge.
`timescale 1ns/10ps
module host_strobe_model (
  // Clock and read data
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  // Request strobes
  output logic            o_wr_stb,
  output logic            o_rd_stb,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // Idle bus; released lines flip so stale values never look valid
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr   = 8'h00;
    o_wdata  = 8'h00;
  end

  // Write: strobe, address and data held over the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_wr_stb <= 1'b1;
    o_addr   <= a;
    o_wdata  <= d;
    @(posedge i_mclk);
    o_wr_stb <= 1'b0;
    o_addr   <= ~a;
    o_wdata  <= ~d;
    #1;
  endtask : wr_reg

  // Read: data is registered on the taking edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_rd_stb <= 1'b1;
    o_addr   <= a;
    @(posedge i_mclk);
    o_rd_stb <= 1'b0;
    o_addr   <= ~a;
    #1;
    d = i_rdata;
  endtask : rd_reg
endmodule : host_strobe_model

/* File: tb/test_boost_limit_status_regs.sv */
// Self-checking bench for the roof, current-limit and status registers.
// Assumes the host model drives the strobes; the bench drives analog status.
`timescale 1ns/10ps
module test_boost_limit_status_regs;
  import boost_limit_pkg::*;
  localparam int LIM = 20;
  logic           mclk = 1'b0;
  logic           srst = 1'b1;
  logic           wr_stb;
  logic           rd_stb;
  logic [7:0]     addr;
  logic [7:0]     wdata;
  logic [7:0]     rdata;
  logic [4:0]     roof;
  current_limit_t cl;
  analog_status_t st = '0;
  int             errors = 0;
  int             comparisons = 0;

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  always #50 mclk = ~mclk;

  boost_limit_status_regs #(.BOOST_LIMIT_CYCLES(LIM)) dut (
    .i_mclk(mclk), .i_srst(srst), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_status(st),
    .o_roof_threshold_code(roof), .o_current_limit(cl)
  );

  host_strobe_model host (
    .i_mclk(mclk), .i_rdata(rdata), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
    .o_addr(addr), .o_wdata(wdata)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk(d, e);
  endtask : rc

  // Status changes at an edge; n edges pass so the synchroniser settles
  task automatic put(input logic [8:0] v, input int n);
    @(posedge mclk);
    st <= v;
    repeat (n) @(posedge mclk);
  endtask : put

  task automatic test_done();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_settings();
    rc(8'h03, 8'h0a);
    rc(8'h04, 8'h1b);
    rc(8'h07, 8'h00);
    host.wr_reg(8'h03, 8'hff);
    chk({3'h0, roof}, 8'h1f);
    rc(8'h03, 8'h1f);
    host.wr_reg(8'h04, 8'hff);
    rc(8'h04, 8'h3f);
    host.wr_reg(8'h04, 8'h28);
    chk({2'h0, cl}, 8'h28);
    host.wr_reg(8'h04, 8'h18);
    chk({2'h0, cl}, 8'h18);
    host.wr_reg(8'h05, 8'hff);
    rc(8'h05, 8'h00);
  endtask : t_settings

  task automatic t_live();
    put(9'h0e2, 4);
    rc(8'h05, 8'h71);
    put(9'h001, 4);
    rc(8'h05, 8'h01);
    put(9'h000, 4);
    rc(8'h05, 8'h00);
  endtask : t_live

  // One-cycle events must latch; a source still high survives the clear
  task automatic t_sticky();
    put(9'h114, 0);
    put(9'h000, 4);
    rc(8'h05, 8'h8a);
    rc(8'h05, 8'h00);
    put(9'h030, 4);
    rc(8'h05, 8'h10);
    put(9'h004, 4);
    rc(8'h05, 8'h02);
    put(9'h000, 4);
    rc(8'h05, 8'h02);
    rc(8'h05, 8'h00);
  endtask : t_sticky

  task automatic t_avg();
    put(9'h028, LIM - 2);
    put(9'h000, 4);
    rc(8'h05, 8'h00);
    put(9'h028, LIM - 1);
    put(9'h000, 4);
    rc(8'h05, 8'h04);
    rc(8'h05, 8'h00);
  endtask : t_avg

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_settings();
    t_live();
    t_sticky();
    t_avg();
    test_done();
  end

  // Whole run is about 150 cycles; twenty times that means a hang
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    test_done();
  end
endmodule : test_boost_limit_status_regs
